// *** pkg/dma_out_defines.svh ***
// Register addresses, field positions, reset values and widths of the OUT DMA status block
`ifndef DMA_OUT_DEFINES_SVH
`define DMA_OUT_DEFINES_SVH

// ----------------------------------------------------------------
// Register addresses (MCU byte space)
// ----------------------------------------------------------------
`define ADDR_CH1_RD_LOW      16'hffb6
`define ADDR_CH1_RD_HIGH     16'hffb5
`define ADDR_CH1_WR_HIGH     16'hffb7
`define ADDR_CH1_WR_LOW      16'hffb8
`define ADDR_CH0_RD_HIGH     16'hffb9
`define ADDR_CH0_RD_LOW      16'hffba
`define ADDR_CH0_WR_HIGH     16'hffbb
`define ADDR_CH0_WR_LOW      16'hffbc
`define ADDR_CH0_FILL_LOW    16'hffeb
`define ADDR_CH0_FILL_HIGH   16'hffec
`define ADDR_BULK_CNT_HIGH   16'hfff1
`define ADDR_BULK_CNT_LOW    16'hfff2
`define ADDR_CH1_FILL_LOW    16'hfff3
`define ADDR_CH1_FILL_HIGH   16'hfff4

// ----------------------------------------------------------------
// Widths, field positions and reset values
// ----------------------------------------------------------------
`define INDEX_W              11
`define COUNT_W              16
`define INDEX_HIGH_W         3
`define RESET_BYTE           8'h00
`define RESET_COUNT          16'h0000
`define RESET_INDEX          11'h000
`define HIGH_PAD_ZERO        5'h00

`endif

// *** pkg/dma_out_pkg.sv ***
// Types shared by the OUT DMA status block
package dma_out_pkg;

	// Live view of one channel's isochronous OUT buffer
	typedef struct packed {
		logic [15:0] content;   // Bytes held right now
		logic [10:0] wr_index;  // Buffer manager write index
		logic [10:0] rd_index;  // DMA read index
	} chan_live_t;

	// Bulk handshake sequencer states
	typedef enum logic [1:0] {
		BULK_IDLE,
		BULK_MOVING,
		BULK_RELEASE
	} bulk_state_t;

endpackage

// *** rtl/dma_out_channel.sv ***
// One channel: SOF fill snapshot, index copies and modulo fill estimate
`timescale 1ns/1ps
`include "dma_out_defines.svh"

module dma_out_channel
	import dma_out_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        sof,
	input  wire chan_live_t  live,
	output logic [15:0]      fill_snapshot,
	output logic [10:0]      wr_copy,
	output logic [10:0]      rd_copy,
	output logic [10:0]      fill_estimate
);

	// ----------------------------------------------------------------
	// Frame snapshot
	// ----------------------------------------------------------------
	// Only SOF loads it, so a read mid-frame is stable for rate matching
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fill_snapshot <= `RESET_COUNT;
		end else if (ce && sof) begin
			fill_snapshot <= live.content;
		end
	end

	// ----------------------------------------------------------------
	// Index copies and estimate
	// ----------------------------------------------------------------
	// Indexes track every cycle that ce is high; firmware may read them at any time
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_copy       <= `RESET_INDEX;
			rd_copy       <= `RESET_INDEX;
			fill_estimate <= `RESET_INDEX;
		end else if (ce) begin
			wr_copy       <= live.wr_index;
			rd_copy       <= live.rd_index;
			// 11-bit subtract wraps by itself, so a pointer wrap stays correct
			fill_estimate <= live.wr_index - live.rd_index;
		end
	end

endmodule

// *** rtl/dma_out_status.sv ***
// OUT DMA status registers: fill snapshots, indexes and bulk packet count
`timescale 1ns/1ps
`include "dma_out_defines.svh"

module dma_out_status
	import dma_out_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// MCU register port, same clock
	input  wire logic [15:0] mcu_addr,
	input  wire logic [7:0]  mcu_wdata,
	input  wire logic        mcu_wr,
	input  wire logic        mcu_rd,
	output logic [7:0]       mcu_rdata,
	output logic             mcu_rvalid,
	// Frame timer
	input  wire logic        sof,
	// Live buffer state per channel
	input  wire chan_live_t  ch0_live,
	input  wire chan_live_t  ch1_live,
	// Channel control bits held in the control register block
	input  wire logic        channel_enable,
	input  wire logic        per_packet_handshake_enable,
	// Bulk datapath handshake
	input  wire logic        bulk_packet_ready,
	input  wire logic        bulk_packet_done,
	output logic             bulk_move_start,
	output logic             channel_enable_clear,
	output logic             bulk_packet_irq,
	output logic             bulk_auto_active,
	// Fill estimates for the rate logic
	output logic [10:0]      ch0_fill_estimate,
	output logic [10:0]      ch1_fill_estimate
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [15:0]  ch0_fill;                // Channel 0 frame snapshot
	logic [15:0]  ch1_fill;                // Channel 1 frame snapshot
	logic [10:0]  ch0_wr;                  // Channel 0 write index copy
	logic [10:0]  ch0_rd;                  // Channel 0 read index copy
	logic [10:0]  ch1_wr;                  // Channel 1 write index copy
	logic [10:0]  ch1_rd;                  // Channel 1 read index copy
	logic [15:0]  bulk_packets_remaining;  // Packets still to handle
	bulk_state_t  bulk_state;              // Handshake sequencer
	bulk_state_t  next_bulk_state;         // Its next value
	logic [7:0]   next_rdata;              // Read mux result
	logic         wr_cnt_high;             // Write hits count high byte
	logic         wr_cnt_low;              // Write hits count low byte
	logic         packet_finished;         // Packet completed in handshake mode

	// ----------------------------------------------------------------
	// Channel instances
	// ----------------------------------------------------------------
	// Both channels are identical, so one module serves each
	dma_out_channel u_ch0 (
		.mclk          (mclk),
		.rst_n         (rst_n),
		.ce            (ce),
		.sof           (sof),
		.live          (ch0_live),
		.fill_snapshot (ch0_fill),
		.wr_copy       (ch0_wr),
		.rd_copy       (ch0_rd),
		.fill_estimate (ch0_fill_estimate)
	);

	dma_out_channel u_ch1 (
		.mclk          (mclk),
		.rst_n         (rst_n),
		.ce            (ce),
		.sof           (sof),
		.live          (ch1_live),
		.fill_snapshot (ch1_fill),
		.wr_copy       (ch1_wr),
		.rd_copy       (ch1_rd),
		.fill_estimate (ch1_fill_estimate)
	);

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	// Only the packet count is writable; all other addresses ignore writes
	assign wr_cnt_high = mcu_wr && (mcu_addr == `ADDR_BULK_CNT_HIGH);
	assign wr_cnt_low  = mcu_wr && (mcu_addr == `ADDR_BULK_CNT_LOW);

	// A packet counts once its move ends while handshake mode is on
	assign packet_finished = (bulk_state == BULK_MOVING) && bulk_packet_done;

	// ----------------------------------------------------------------
	// Bulk packet count
	// ----------------------------------------------------------------
	// A firmware byte write wins over a decrement in the same cycle:
	// firmware only loads the count while the channel is idle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bulk_packets_remaining <= `RESET_COUNT;
		end else if (ce) begin
			if (wr_cnt_high) begin
				bulk_packets_remaining[15:8] <= mcu_wdata;
			end else if (wr_cnt_low) begin
				bulk_packets_remaining[7:0] <= mcu_wdata;
			end else if (packet_finished && (bulk_packets_remaining != `RESET_COUNT)) begin
				// Never wraps below zero
				bulk_packets_remaining <= bulk_packets_remaining - 16'h0001;
			end
		end
	end

	// Automatic handling lasts while packets remain, up to 65535 of them
	assign bulk_auto_active = channel_enable && per_packet_handshake_enable
		&& (bulk_packets_remaining != `RESET_COUNT);

	// ----------------------------------------------------------------
	// Handshake sequencer
	// ----------------------------------------------------------------
	// Idle until enabled with a packet waiting, then move exactly one
	always_comb begin
		next_bulk_state = bulk_state;
		case (bulk_state)
			BULK_IDLE: begin
				if (channel_enable && per_packet_handshake_enable && bulk_packet_ready) begin
					next_bulk_state = BULK_MOVING;
				end
			end
			BULK_MOVING: begin
				if (bulk_packet_done) begin
					next_bulk_state = BULK_RELEASE;
				end
			end
			BULK_RELEASE: begin
				// Wait for the enable to drop so one enable moves one packet,
				// unless packets remain for automatic handling
				if (!channel_enable || (bulk_packets_remaining != `RESET_COUNT)) begin
					next_bulk_state = BULK_IDLE;
				end
			end
			default: begin
				next_bulk_state = BULK_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bulk_state <= BULK_IDLE;
		end else if (ce) begin
			bulk_state <= next_bulk_state;
		end
	end

	// ----------------------------------------------------------------
	// Handshake outputs
	// ----------------------------------------------------------------
	// Start pulse tells the datapath to fetch one packet
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bulk_move_start <= 1'b0;
		end else if (ce) begin
			bulk_move_start <= (bulk_state == BULK_IDLE) && (next_bulk_state == BULK_MOVING);
		end
	end

	// Per-packet mode clears the enable and interrupts after every packet;
	// with packets left in the count the enable stays and no interrupt fires
	// until the last one, so firmware is not involved between packets
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			channel_enable_clear <= 1'b0;
			bulk_packet_irq      <= 1'b0;
		end else if (ce) begin
			channel_enable_clear <= packet_finished
				&& (bulk_packets_remaining <= 16'h0001);
			bulk_packet_irq      <= packet_finished
				&& (bulk_packets_remaining <= 16'h0001);
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// Pure decode: no read changes any state; unmapped bytes read zero
	always_comb begin
		next_rdata = `RESET_BYTE;
		case (mcu_addr)
			`ADDR_CH0_FILL_LOW:  next_rdata = ch0_fill[7:0];
			`ADDR_CH0_FILL_HIGH: next_rdata = ch0_fill[15:8];
			`ADDR_CH1_FILL_LOW:  next_rdata = ch1_fill[7:0];
			`ADDR_CH1_FILL_HIGH: next_rdata = ch1_fill[15:8];
			`ADDR_BULK_CNT_LOW:  next_rdata = bulk_packets_remaining[7:0];
			`ADDR_BULK_CNT_HIGH: next_rdata = bulk_packets_remaining[15:8];
			`ADDR_CH0_WR_LOW:    next_rdata = ch0_wr[7:0];
			`ADDR_CH0_WR_HIGH:   next_rdata = {`HIGH_PAD_ZERO, ch0_wr[10:8]};
			`ADDR_CH1_WR_LOW:    next_rdata = ch1_wr[7:0];
			`ADDR_CH1_WR_HIGH:   next_rdata = {`HIGH_PAD_ZERO, ch1_wr[10:8]};
			`ADDR_CH0_RD_LOW:    next_rdata = ch0_rd[7:0];
			`ADDR_CH0_RD_HIGH:   next_rdata = {`HIGH_PAD_ZERO, ch0_rd[10:8]};
			`ADDR_CH1_RD_LOW:    next_rdata = ch1_rd[7:0];
			`ADDR_CH1_RD_HIGH:   next_rdata = {`HIGH_PAD_ZERO, ch1_rd[10:8]};
			default:             next_rdata = `RESET_BYTE;
		endcase
	end

	// Read data registered one cycle after the strobe
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mcu_rdata  <= `RESET_BYTE;
			mcu_rvalid <= 1'b0;
		end else if (ce) begin
			mcu_rvalid <= mcu_rd;
			if (mcu_rd) begin
				mcu_rdata <= next_rdata;
			end
		end
	end

endmodule

// *** dv/dma_out_status_sva.sv ***
// Concurrent checks on the ports of the OUT DMA status block
`timescale 1ns/1ps
`include "dma_out_defines.svh"
module dma_out_status_chk import dma_out_pkg::*; (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        ce,
	input wire logic [15:0] mcu_addr,
	input wire logic        mcu_rd,
	input wire logic [7:0]  mcu_rdata,
	input wire logic        mcu_rvalid,
	input wire chan_live_t  ch0_live,
	input wire logic        channel_enable,
	input wire logic        per_packet_handshake_enable,
	input wire logic        bulk_packet_done,
	input wire logic        bulk_move_start,
	input wire logic        channel_enable_clear,
	input wire logic        bulk_packet_irq,
	input wire logic        bulk_auto_active,
	input wire logic [10:0] ch0_fill_estimate
);
	// ----------------------------------------------------------------
	// One clock domain, so one default clocking and disable
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	read_answer_a: assert property ((mcu_rd && ce) |=> mcu_rvalid) else $error("read not answered");
	answer_cause_a: assert property (mcu_rvalid |-> $past(mcu_rd)) else $error("answer without read");
	high_pad_a: assert property ((mcu_rvalid && $past(mcu_addr) == `ADDR_CH0_WR_HIGH) |-> mcu_rdata[7:3] == 5'h00)
		else $error("reserved index bits not zero");
	unmapped_zero_a: assert property ((mcu_rvalid && $past(mcu_addr) == 16'hff00) |-> mcu_rdata == 8'h00)
		else $error("unmapped read not zero");
	fill_mod_a: assert property ($past(ce) |-> ch0_fill_estimate == 11'($past(ch0_live.wr_index) - $past(ch0_live.rd_index)))
		else $error("fill estimate wrong");
	start_cause_a: assert property (bulk_move_start |-> $past(channel_enable) && $past(per_packet_handshake_enable))
		else $error("move start without enable");
	irq_pair_a: assert property (bulk_packet_irq |-> channel_enable_clear && $past(bulk_packet_done) ##1 !bulk_packet_irq)
		else $error("interrupt not paired with done and clear");
	// The last packet empties the count, so automatic handling must be over when its interrupt fires
	auto_stop_a: assert property (bulk_packet_irq |-> !bulk_auto_active)
		else $error("automatic handling still active after last packet");
endmodule

// *** dv/dma_out_status_tb_top.sv ***
// Self-checking testbench for the OUT DMA status block
`timescale 1ns/1ps
`include "dma_out_defines.svh"
module dma_out_status_tb_top import dma_out_pkg::*; ;
	logic        mclk, rst_n, ce, mcu_wr, mcu_rd, sof;   // Bench-driven controls
	logic        en, hsk, rdy, done;                     // Channel control and bulk datapath
	logic [15:0] addr;                                   // Register address
	logic [7:0]  wdata;                                  // Write data
	chan_live_t  l0, l1;                                 // Live buffer state
	wire  [7:0]  rdata;
	wire         rvalid, start, clr, irq, auto;
	wire  [10:0] est0, est1;
	int          fail_count, cmp_count;

	dma_out_status i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .mcu_addr(addr), .mcu_wdata(wdata), .mcu_wr(mcu_wr),
		.mcu_rd(mcu_rd), .mcu_rdata(rdata), .mcu_rvalid(rvalid), .sof(sof), .ch0_live(l0), .ch1_live(l1),
		.channel_enable(en), .per_packet_handshake_enable(hsk), .bulk_packet_ready(rdy), .bulk_packet_done(done),
		.bulk_move_start(start), .channel_enable_clear(clr), .bulk_packet_irq(irq), .bulk_auto_active(auto),
		.ch0_fill_estimate(est0), .ch1_fill_estimate(est1));

	// ----------------------------------------------------------------
	// Clock, compare, bus tasks
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge mclk); addr = a; wdata = d; mcu_wr = 1'b1;
		@(negedge mclk); mcu_wr = 1'b0;
	endtask
	// Read answer shows one cycle after the strobe
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge mclk); addr = a; mcu_rd = 1'b1;
		@(negedge mclk); mcu_rd = 1'b0;
		chk({15'h0000, rvalid}, 16'h0001);
		chk({8'h00, rdata}, {8'h00, e});
	endtask
	// One bulk packet; irq and clear expected only on the last one
	// Ready is raised on a falling edge, never between edges
	task pkt(input logic last);
		@(negedge mclk);
		rdy = 1'b1;
		repeat (8) if (start !== 1'b1) @(negedge mclk);
		rdy = 1'b0;
		chk({15'h0000, start}, 16'h0001);
		@(negedge mclk); done = 1'b1;
		@(negedge mclk); done = 1'b0;
		// Irq and clear stand for one cycle only, so look right after done falls
		chk({14'h0000, irq, clr}, {14'h0000, last, last});
	endtask
	task results();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [15:0] m [14] = '{16'hffb5, 16'hffb6, 16'hffb7, 16'hffb8, 16'hffb9, 16'hffba, 16'hffbb, 16'hffbc,
			16'hffeb, 16'hffec, 16'hfff1, 16'hfff2, 16'hfff3, 16'hfff4};
		foreach (m[i]) rd(m[i], 8'h00);
		rd(16'hff00, 8'h00);
		$display("test reset done");
	endtask
	task t_count();
		wr(`ADDR_BULK_CNT_HIGH, 8'h12);
		wr(`ADDR_BULK_CNT_LOW, 8'h34);
		wr(`ADDR_CH0_FILL_HIGH, 8'h55);
		wr(`ADDR_CH0_WR_LOW, 8'h55);
		repeat (2) rd(`ADDR_BULK_CNT_HIGH, 8'h12);
		repeat (2) rd(`ADDR_BULK_CNT_LOW, 8'h34);
		rd(`ADDR_CH0_FILL_HIGH, 8'h00);
		rd(`ADDR_CH0_WR_LOW, 8'h00);
		$display("test count done");
	endtask
	// Snapshot must ignore live changes after the frame start
	task t_snap();
		l0.content = 16'habcd; l1.content = 16'h1234; sof = 1'b1;
		@(negedge mclk); sof = 1'b0; l0.content = 16'h0f0f; l1.content = 16'h0707;
		rd(`ADDR_CH0_FILL_LOW, 8'hcd);
		rd(`ADDR_CH0_FILL_HIGH, 8'hab);
		rd(`ADDR_CH1_FILL_LOW, 8'h34);
		rd(`ADDR_CH1_FILL_HIGH, 8'h12);
		$display("test snapshot done");
	endtask
	// Channel 0 read index sits past write index: estimate wraps
	task t_ptr();
		l0.wr_index = 11'h005; l0.rd_index = 11'h7fe; l1.wr_index = 11'h6a5; l1.rd_index = 11'h123;
		repeat (2) @(negedge mclk);
		chk({5'h00, est0}, 16'h0007);
		chk({5'h00, est1}, 16'h0582);
		rd(`ADDR_CH0_WR_LOW, 8'h05);
		rd(`ADDR_CH0_WR_HIGH, 8'h00);
		rd(`ADDR_CH0_RD_LOW, 8'hfe);
		rd(`ADDR_CH0_RD_HIGH, 8'h07);
		rd(`ADDR_CH1_WR_LOW, 8'ha5);
		rd(`ADDR_CH1_WR_HIGH, 8'h06);
		rd(`ADDR_CH1_RD_LOW, 8'h23);
		rd(`ADDR_CH1_RD_HIGH, 8'h01);
		$display("test pointers done");
	endtask
	// Two packets automatically, then plain per-packet mode
	task t_bulk();
		wr(`ADDR_BULK_CNT_HIGH, 8'h00);
		wr(`ADDR_BULK_CNT_LOW, 8'h02);
		@(negedge mclk); en = 1'b1; hsk = 1'b1;
		#1 chk({15'h0000, auto}, 16'h0001);
		pkt(1'b0);
		rd(`ADDR_BULK_CNT_LOW, 8'h01);
		pkt(1'b1);
		// Enable still high here, so only the empty count can end automatic handling
		chk({15'h0000, auto}, 16'h0000);
		en = 1'b0;
		rd(`ADDR_BULK_CNT_LOW, 8'h00);
		en = 1'b1;
		pkt(1'b1);
		en = 1'b0;
		// A packet in plain per-packet mode must not wrap the empty count
		rd(`ADDR_BULK_CNT_HIGH, 8'h00);
		$display("test bulk done");
	endtask
	// Clock enable low holds snapshot and count; a later frame start refreshes
	task t_freeze();
		@(negedge mclk);
		ce = 1'b0;
		sof = 1'b1;
		l0.content = 16'h5a5a;
		addr = `ADDR_BULK_CNT_LOW;
		wdata = 8'h77;
		mcu_wr = 1'b1;
		@(negedge mclk);
		ce = 1'b1;
		sof = 1'b0;
		mcu_wr = 1'b0;
		rd(`ADDR_CH0_FILL_HIGH, 8'hab);
		rd(`ADDR_BULK_CNT_LOW, 8'h00);
		sof = 1'b1;
		@(negedge mclk);
		sof = 1'b0;
		rd(`ADDR_CH0_FILL_LOW, 8'h5a);
		$display("test freeze done");
	endtask

	initial begin
		{rst_n, mcu_wr, mcu_rd, sof, en, hsk, rdy, done} = 8'h00;
		ce = 1'b1; addr = 16'h0000; wdata = 8'h00; l0 = '0; l1 = '0;
		fail_count = 0; cmp_count = 0;
		repeat (3) @(posedge mclk);
		@(negedge mclk); rst_n = 1'b1;
		t_reset();
		t_count();
		t_snap();
		t_ptr();
		t_bulk();
		t_freeze();
		results();
	end
	// Watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge mclk);
		fail_count++;
		results();
	end
endmodule

bind dma_out_status dma_out_status_chk i_chk (.mclk(mclk), .rst_n(rst_n), .ce(ce), .mcu_addr(mcu_addr),
	.mcu_rd(mcu_rd), .mcu_rdata(mcu_rdata), .mcu_rvalid(mcu_rvalid), .ch0_live(ch0_live),
	.channel_enable(channel_enable), .per_packet_handshake_enable(per_packet_handshake_enable),
	.bulk_packet_done(bulk_packet_done), .bulk_move_start(bulk_move_start),
	.channel_enable_clear(channel_enable_clear), .bulk_packet_irq(bulk_packet_irq),
	.bulk_auto_active(bulk_auto_active), .ch0_fill_estimate(ch0_fill_estimate));
